/* logic/gict_pkg.sv */
package gict_pkg;

	localparam int NUM_PINS = 21;
	localparam int LOW_PINS = 16;
	localparam int HIGH_PINS = 5;
	localparam int REG_W = 16;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;

	// Register indices; the byte address of each is four times its index.
	localparam logic [IDX_W-1:0] IDX_STAT_LO = 10'h088;
	localparam logic [IDX_W-1:0] IDX_STAT_HI = 10'h08a;
	localparam logic [IDX_W-1:0] IDX_EN_LO = 10'h08c;
	localparam logic [IDX_W-1:0] IDX_EN_HI = 10'h08e;
	localparam logic [IDX_W-1:0] IDX_TYP_LO = 10'h090;
	localparam logic [IDX_W-1:0] IDX_TYP_HI = 10'h092;
	localparam logic [IDX_W-1:0] IDX_POL_LO = 10'h094;
	localparam logic [IDX_W-1:0] IDX_POL_HI = 10'h096;
	localparam logic [IDX_W-1:0] IDX_PIN_LO = 10'h0a0;
	localparam logic [IDX_W-1:0] IDX_PIN_HI = 10'h0a2;

	localparam logic [NUM_PINS-1:0] EN_RST = 21'h000000;
	localparam logic [NUM_PINS-1:0] TYP_RST = 21'h000000;
	localparam logic [NUM_PINS-1:0] POL_RST = 21'h000000;
	localparam logic [NUM_PINS-1:0] STAT_RST = 21'h1fffff;
	localparam logic [NUM_PINS-1:0] PIN_RST = 21'h000000;

	localparam logic TRIG_EDGE = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* logic/gict_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module gict_pin_sync #(
	parameter int N = 21
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [N-1:0] pin_raw,
	output logic [N-1:0] pin_level,
	output logic [N-1:0] pin_change
);
	import gict_pkg::*;

	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
		logic [N-1:0] chg;
	} gict_sync_t;

	gict_sync_t q, d;
	logic [N-1:0] agree;

	// ----------------------------------------
	// Three-stage synchroniser and change detect.
	// ----------------------------------------
	always_comb begin
		d = q;
		d.s1 = pin_raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		agree = ~(q.s2 ^ q.s3);
		d.lvl = (q.lvl & ~agree) | (q.s3 & agree);
		d.chg = d.lvl ^ q.lvl; // [R6]
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pin_level = q.lvl;
	assign pin_change = q.chg;

endmodule

`default_nettype wire

/* logic/gict_top.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Enable bits for pins 15..0, reset clear.
// R2: Enable bits pins 20..16 in bits 4..0.
// R3: High-half bits 15..5 read zero, written zero.
// R4: Trigger bits pins 15..0: 1 edge, 0 level.
// R5: Trigger bits pins 20..16 in bits 4..0.
// R6: Edge mode requests on any pin change.
// R7: Level mode requests while pin at active level.
// R8: Polarity bit: 1 high, 0 low, edge ignores.
// R9: Status set on trigger, cleared writing one.
// R10: Disabled pin never signals the interrupt output.
// R11: Interrupt output is OR of status AND enable.
module gict_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [gict_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [gict_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [gict_pkg::NUM_PINS-1:0] gpio_pin_in,
	output logic irq_out
);
	import gict_pkg::*;

	// ----------------------------------------
	// State of the block.
	// ----------------------------------------
	typedef struct packed {
		logic awready;
		logic aw_held;
		logic [IDX_W-1:0] aw_idx;
		logic wready;
		logic w_held;
		logic [REG_W-1:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NUM_PINS-1:0] pin_irq_allow;
		logic [NUM_PINS-1:0] pin_trigger_edge_sel;
		logic [NUM_PINS-1:0] pin_active_polarity;
		logic [NUM_PINS-1:0] pin_irq_pending;
		logic irq;
	} gict_state_t;

	gict_state_t q, d;
	logic [NUM_PINS-1:0] pin_level;
	logic [NUM_PINS-1:0] pin_change;
	wire logic [NUM_PINS-1:0] hit;
	logic [NUM_PINS-1:0] clr;
	logic [REG_W-1:0] wmask;
	logic [IDX_W-1:0] r_idx;
	logic wr_fire;

	// ----------------------------------------
	// Pin input conditioning.
	// ----------------------------------------
	gict_pin_sync #(
		.N(NUM_PINS)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin_raw(gpio_pin_in),
		.pin_level(pin_level),
		.pin_change(pin_change)
	);

	// ----------------------------------------
	// Per-pin trigger selection.
	// ----------------------------------------
	// Edge mode takes any change, level mode the chosen level.
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		assign hit[p] = (q.pin_trigger_edge_sel[p] == TRIG_EDGE) ? pin_change[p] // [R6]
			: (pin_level[p] == q.pin_active_polarity[p]); // [R7] [R8]
	end

	// ----------------------------------------
	// Register helpers.
	// ----------------------------------------
	function automatic logic [REG_W-1:0] merge(
		input logic [REG_W-1:0] old,
		input logic [REG_W-1:0] data,
		input logic [1:0] strb
	);
		logic [REG_W-1:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	function automatic logic [REG_W-1:0] lo_half(input logic [NUM_PINS-1:0] v);
		return v[LOW_PINS-1:0];
	endfunction

	function automatic logic [REG_W-1:0] hi_half(input logic [NUM_PINS-1:0] v);
		return {{(REG_W-HIGH_PINS){1'b0}}, v[NUM_PINS-1:LOW_PINS]}; // [R3]
	endfunction

	function automatic logic [31:0] word(input logic [REG_W-1:0] v);
		return {{(32-REG_W){1'b0}}, v};
	endfunction

	function automatic logic [NUM_PINS-1:0] wr_lo(
		input logic [NUM_PINS-1:0] cur,
		input logic [REG_W-1:0] data,
		input logic [1:0] strb
	);
		logic [REG_W-1:0] m;
		m = merge(lo_half(cur), data, strb);
		return {cur[NUM_PINS-1:LOW_PINS], m};
	endfunction

	function automatic logic [NUM_PINS-1:0] wr_hi(
		input logic [NUM_PINS-1:0] cur,
		input logic [REG_W-1:0] data,
		input logic [1:0] strb
	);
		logic [REG_W-1:0] m;
		m = merge(hi_half(cur), data, strb);
		return {m[HIGH_PINS-1:0], cur[LOW_PINS-1:0]}; // [R3]
	endfunction

	// ----------------------------------------
	// Bus handshakes, register file and detection.
	// ----------------------------------------
	always_comb begin
		d = q;
		clr = '0;
		r_idx = s_axi_araddr[ADDR_W-1:2];
		wr_fire = q.aw_held && q.w_held && !q.bvalid;
		wmask = merge('0, q.w_data, q.w_strb);

		// ----------------------------------------
		// Write channel.
		// ----------------------------------------
		if (q.awready && s_axi_awvalid) begin
			d.awready = 1'b0;
			d.aw_held = 1'b1;
			d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
		end
		if (q.wready && s_axi_wvalid) begin
			d.wready = 1'b0;
			d.w_held = 1'b1;
			d.w_data = s_axi_wdata[REG_W-1:0];
			d.w_strb = s_axi_wstrb[1:0];
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		if (wr_fire) begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case (q.aw_idx)
				IDX_EN_LO: begin
					d.pin_irq_allow = wr_lo(q.pin_irq_allow, q.w_data, q.w_strb); // [R1]
				end
				IDX_EN_HI: begin
					d.pin_irq_allow = wr_hi(q.pin_irq_allow, q.w_data, q.w_strb); // [R2]
				end
				IDX_TYP_LO: begin
					d.pin_trigger_edge_sel = wr_lo(q.pin_trigger_edge_sel, q.w_data, q.w_strb); // [R4]
				end
				IDX_TYP_HI: begin
					d.pin_trigger_edge_sel = wr_hi(q.pin_trigger_edge_sel, q.w_data, q.w_strb); // [R5]
				end
				IDX_POL_LO: begin
					d.pin_active_polarity = wr_lo(q.pin_active_polarity, q.w_data, q.w_strb); // [R8]
				end
				IDX_POL_HI: begin
					d.pin_active_polarity = wr_hi(q.pin_active_polarity, q.w_data, q.w_strb); // [R8]
				end
				IDX_STAT_LO: begin
					clr = {{HIGH_PINS{1'b0}}, wmask}; // [R9]
				end
				IDX_STAT_HI: begin
					clr = {wmask[HIGH_PINS-1:0], {LOW_PINS{1'b0}}}; // [R9]
				end
				IDX_PIN_LO, IDX_PIN_HI: begin
					d.bresp = RESP_OKAY;
				end
				default: begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end

		// ----------------------------------------
		// Read channel.
		// ----------------------------------------
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
		if (q.arready && s_axi_arvalid) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			case (r_idx)
				IDX_EN_LO: begin
					d.rdata = word(lo_half(q.pin_irq_allow));
				end
				IDX_EN_HI: begin
					d.rdata = word(hi_half(q.pin_irq_allow));
				end
				IDX_TYP_LO: begin
					d.rdata = word(lo_half(q.pin_trigger_edge_sel));
				end
				IDX_TYP_HI: begin
					d.rdata = word(hi_half(q.pin_trigger_edge_sel));
				end
				IDX_POL_LO: begin
					d.rdata = word(lo_half(q.pin_active_polarity));
				end
				IDX_POL_HI: begin
					d.rdata = word(hi_half(q.pin_active_polarity));
				end
				IDX_STAT_LO: begin
					d.rdata = word(lo_half(q.pin_irq_pending));
				end
				IDX_STAT_HI: begin
					d.rdata = word(hi_half(q.pin_irq_pending));
				end
				IDX_PIN_LO: begin
					d.rdata = word(lo_half(pin_level));
				end
				IDX_PIN_HI: begin
					d.rdata = word(hi_half(pin_level));
				end
				default: begin
					d.rdata = 32'h00000000;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end

		// ----------------------------------------
		// Status and interrupt.
		// ----------------------------------------
		// A new request wins over a clear in the same cycle.
		d.pin_irq_pending = (q.pin_irq_pending & ~clr) | hit; // [R9]
		d.irq = |(q.pin_irq_pending & q.pin_irq_allow); // [R10] [R11]
	end

	// ----------------------------------------
	// State registers.
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
			q.pin_irq_allow <= EN_RST; // [R1] [R2]
			q.pin_trigger_edge_sel <= TYP_RST; // [R4]
			q.pin_active_polarity <= POL_RST; // [R8]
			q.pin_irq_pending <= STAT_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign irq_out = q.irq;

endmodule

`default_nettype wire

/* test/gict_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module gict_chk
	import gict_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic wtake, rtake;
	assign wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign rtake = s_axi_arvalid && s_axi_arready;
	a_aw_busy: assert property (wtake |=> !s_axi_awready && !s_axi_wready) else $error("write ready not dropped");
	a_b_answer: assert property (wtake |-> ##[1:2] s_axi_bvalid) else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_ar_busy: assert property (rtake |=> !s_axi_arready) else $error("read ready not dropped");
	a_r_answer: assert property (rtake |=> s_axi_rvalid) else $error("read data late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
	a_hi_rsvd: assert property (rtake && (s_axi_araddr[11:2] == IDX_EN_HI || s_axi_araddr[11:2] == IDX_TYP_HI)
		|=> s_axi_rdata[15:5] == 11'h000) else $error("reserved bits set");
	a_unmap_err: assert property (rtake && s_axi_araddr == 12'hffc |=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule
bind gict_top gict_chk gict_chk_i (.ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* test/gict_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gict_pin_model (
	input wire logic ref_clk,
	input wire logic [gict_pkg::NUM_PINS-1:0] pin_cmd,
	output logic [gict_pkg::NUM_PINS-1:0] pin_out
);
	import gict_pkg::*;
	// Pins change just after a clock edge, unrelated to any bus cycle.
	initial pin_out = '0;
	always @(posedge ref_clk) begin
		pin_out <= pin_cmd;
	end
endmodule
`default_nettype wire

/* test/gict_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module gict_top_tb_top;
	import gict_pkg::*;
	typedef struct {logic [11:0] a; logic [15:0] rs, w, e;} gict_row_t;
	logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_out;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [NUM_PINS-1:0] gpio_pin_in, pin_cmd;
	int n_mismatch = 0, checked = 0;
	gict_row_t rows[6] = '{
		'{12'h230, 16'h0000, 16'hffff, 16'hffff},
		'{12'h238, 16'h0000, 16'h001f, 16'h001f},
		'{12'h240, 16'h0000, 16'ha5a5, 16'ha5a5},
		'{12'h248, 16'h0000, 16'h001f, 16'h001f},
		'{12'h250, 16'h0000, 16'h5a5a, 16'h5a5a},
		'{12'h258, 16'h0000, 16'h001f, 16'h001f}};
	gict_top gict_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .gpio_pin_in(gpio_pin_in), .irq_out(irq_out));
	gict_pin_model gict_pin_model_i (.ref_clk(ref_clk), .pin_cmd(pin_cmd), .pin_out(gpio_pin_in));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task complete_run;
		if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tmo(int i);
		if (i >= 50) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task wt(int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task wr(logic [11:0] a, logic [15:0] d, logic [1:0] er = RESP_OKAY);
		int i;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		tmo(i);
		chk(32'(s_axi_bresp), 32'(er));
	endtask
	task rd(logic [11:0] a, logic [15:0] e, logic [1:0] er = RESP_OKAY);
		int i;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		tmo(i);
		chk(s_axi_rdata, {16'h0000, e});
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h3;
		pin_cmd = '0;
		wt(2);
		rst_n <= 1'b1;
		rd(12'h220, 16'hffff);
		rd(12'h228, 16'h001f);
		chk(32'(irq_out), 32'h0);
		foreach (rows[k]) begin
			rd(rows[k].a, rows[k].rs);
			wr(rows[k].a, rows[k].w);
			rd(rows[k].a, rows[k].e);
		end
		chk(32'(irq_out), 32'h1);
		s_axi_wstrb <= 4'h1;
		wr(12'h250, 16'hffff);
		s_axi_wstrb <= 4'h3;
		rd(12'h250, 16'h5aff);
		wr(12'hffc, 16'h1234, RESP_SLVERR);
		rd(12'hffc, 16'h0000, RESP_SLVERR);
		wr(12'h240, 16'hffff);
		wr(12'h248, 16'h001f);
		wr(12'h230, 16'h0000);
		wr(12'h238, 16'h0000);
		wt(8);
		wr(12'h220, 16'hffff);
		wr(12'h228, 16'h001f);
		rd(12'h220, 16'h0000);
		pin_cmd <= 21'h000008;
		wt(10);
		rd(12'h220, 16'h0008);
		chk(32'(irq_out), 32'h0);
		wr(12'h230, 16'h0008);
		wt(3);
		chk(32'(irq_out), 32'h1);
		wr(12'h220, 16'h0008);
		wt(3);
		chk(32'(irq_out), 32'h0);
		pin_cmd <= '0;
		wt(10);
		chk(32'(irq_out), 32'h1);
		wr(12'h230, 16'h0000);
		wt(3);
		chk(32'(irq_out), 32'h0);
		wr(12'h248, 16'h001b);
		wr(12'h258, 16'h0004);
		wr(12'h228, 16'h0004);
		wr(12'h238, 16'h0004);
		wt(3);
		chk(32'(irq_out), 32'h0);
		pin_cmd <= 21'h040000;
		wt(10);
		chk(32'(irq_out), 32'h1);
		rd(12'h288, 16'h0004);
		wr(12'h228, 16'h0004);
		wt(3);
		chk(32'(irq_out), 32'h1);
		pin_cmd <= '0;
		wt(10);
		wr(12'h228, 16'h0004);
		wt(3);
		chk(32'(irq_out), 32'h0);
		rst_n <= 1'b0;
		wt(2);
		rst_n <= 1'b1;
		chk(32'(irq_out), 32'h0);
		rd(12'h230, 16'h0000);
		rd(12'h248, 16'h0000);
		complete_run();
	end
endmodule
`default_nettype wire
